/* core/filter_seq_cfg.svh */
// Constants for the filter readout sequencer.
`ifndef FILTER_SEQ_CFG_SVH
`define FILTER_SEQ_CFG_SVH
`define WORD_W 16
`define CHIPS 4
`define MODE_W 3
`define STEP_W 2
`define PROD_HI 30
`define PROD_LO 15
// Mode field on the I/O bus.
`define MODE_LO_BIT 0
`define MODE_HI_BIT 2
// Slope latch bits on the I/O bus.
`define SLOPE_RISE_BIT 0
`define SLOPE_FALL_BIT 1
`define EDGE_CLEAR_BIT 2
// Sequencer lookup words {enable4..1 low-true, final, count}.
`define ROM_CHIP2 6'o66
`define ROM_CHIP1 6'o72
`define ROM_CHIP3 6'o56
`define ROM_CHIP1_MORE 6'o71
`define ROM_CHIP4 6'o36
`define ROM_CHIP2_MORE 6'o65
`define ROM_CHIP3_MORE 6'o55
`define ROM_IDLE 6'o76
`define STEP_ZERO 2'h0
`define STEP_ONE 2'h1
`define STEP_TWO 2'h2
`define STEP_THREE 2'h3
`define ENABLES_OFF 4'hf
`define WORD_ZERO 16'h0000
`endif

/* core/filter_seq_pkg.sv */
// Types shared by the filter readout sequencer files.
package filter_seq_pkg;
   typedef struct packed {
      logic [3:0] chip_enable_n;
      logic final_step;
      logic count_on;
   } rom_word_type;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_PUSH,
      SEQ_DONE
   } seq_state_type;

   typedef struct packed {
      logic [3:0] overload;
      logic [3:0] overflow;
      logic clip_a;
      logic clip_b;
   } overload_in_type;
endpackage

/* core/two_phase_driver.sv */
// Non-overlapping two-phase clock driver.
`timescale 1ns/1ps
module two_phase_driver (
   input wire logic clk,
   input wire logic srst,
   input wire logic timing_clock_in,
   output logic phase_one_q,
   output logic phase_two_q
);
   // Each phase needs the other low in the previous cycle, so a dead
   // cycle separates them and both are never high together.
   always_ff @(posedge clk) begin
      if (srst) begin
         phase_one_q <= 1'b0;
         phase_two_q <= 1'b0;
      end else begin
         phase_one_q <= timing_clock_in & ~phase_two_q;
         phase_two_q <= ~timing_clock_in & ~phase_one_q;
      end
   end
endmodule

/* core/two_entry_buffer.sv */
// Two-entry skid buffer with registered valid, ready and data.
`timescale 1ns/1ps
`include "filter_seq_cfg.svh"
module two_entry_buffer (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready_q,
   input wire logic [`WORD_W-1:0] in_data,
   output logic out_valid_q,
   input wire logic out_ready,
   output logic [`WORD_W-1:0] out_data_q
);
   logic skid_valid_q;
   logic [`WORD_W-1:0] skid_data_q;
   logic push;
   logic pop;

   assign push = in_valid & in_ready_q;
   assign pop = out_valid_q & out_ready;

   always_ff @(posedge clk) begin
      if (srst) begin
         out_valid_q <= 1'b0;
         skid_valid_q <= 1'b0;
         in_ready_q <= 1'b1;
         out_data_q <= `WORD_ZERO;
         skid_data_q <= `WORD_ZERO;
      end else begin
         if (!out_valid_q || pop) begin
            out_valid_q <= skid_valid_q | push;
            out_data_q <= skid_valid_q ? skid_data_q : in_data;
            skid_valid_q <= skid_valid_q & push;
            skid_data_q <= in_data;
            in_ready_q <= 1'b1;
         end else if (push) begin
            // Receiver stalled: park the word and refuse the next one.
            skid_valid_q <= 1'b1;
            skid_data_q <= in_data;
            in_ready_q <= 1'b0;
         end
      end
   end
endmodule

/* core/filter_readout_sequencer.sv */
// Filter board support logic: clocks, requests, sequencing, overload.
`timescale 1ns/1ps
`include "filter_seq_cfg.svh"
module filter_readout_sequencer (
   input wire logic clk,
   input wire logic srst,
   input wire logic timing_clock_in,
   output logic phase_one_q,
   output logic phase_two_q,
   input wire logic sample_valid,
   input wire logic [`WORD_W-1:0] sample_data,
   input wire logic [`WORD_W-1:0] cosine_value,
   input wire logic [`WORD_W-1:0] sine_value,
   output logic sync_strobe_q,
   output logic [`WORD_W-1:0] real_product_q,
   output logic [`WORD_W-1:0] imag_product_q,
   input wire logic [`CHIPS-1:0] chip_result_ready,
   input wire logic [`CHIPS*`WORD_W-1:0] chip_data,
   output logic [`CHIPS-1:0] chip_enable_n_q,
   input wire logic [`WORD_W-1:0] io_bus_in,
   input wire logic mode_write_strobe,
   input wire logic request_clear_strobe,
   output logic memory_access_request_n,
   output logic final_chip_q,
   output logic data_valid_q,
   input wire logic data_ready,
   output logic [`WORD_W-1:0] data_bus_q,
   input wire filter_seq_pkg::overload_in_type overload_in,
   output logic overload_indicator_q,
   input wire logic overload_clear_strobe,
   input wire logic overload_read_gate,
   output logic io_bus_bit_fifteen,
   output logic io_bus_bit_zero,
   output logic io_bus_read_oe_q,
   input wire logic slope_write_strobe,
   input wire logic trigger_in,
   output logic trigger_out_n_q
);
   // Selected chip-ready set for one mode code.
   function automatic logic ready_pick(
      input logic [`MODE_W-1:0] mode,
      input logic [`CHIPS-1:0] rdy
   );
      case (mode)
         3'h0: ready_pick = rdy[1];
         3'h1: ready_pick = rdy[0];
         3'h2: ready_pick = rdy[2];
         3'h3: ready_pick = rdy[0] & rdy[2];
         3'h4: ready_pick = rdy[3];
         3'h5: ready_pick = rdy[0] & rdy[1];
         3'h6: ready_pick = rdy[2] & rdy[3];
         default: ready_pick = &rdy;
      endcase
   endfunction

   // Sequencer lookup: mode code high, step count low.
   function automatic filter_seq_pkg::rom_word_type rom_lookup(
      input logic [`MODE_W+`STEP_W-1:0] addr
   );
      logic [5:0] w;
      w = `ROM_IDLE;
      case (addr)
         {3'h0, `STEP_ZERO}: w = `ROM_CHIP2;
         {3'h1, `STEP_ZERO}: w = `ROM_CHIP1;
         {3'h2, `STEP_ZERO}: w = `ROM_CHIP3;
         {3'h3, `STEP_ZERO}: w = `ROM_CHIP1_MORE;
         {3'h3, `STEP_ONE}: w = `ROM_CHIP3;
         {3'h4, `STEP_ZERO}: w = `ROM_CHIP4;
         {3'h5, `STEP_ZERO}: w = `ROM_CHIP1_MORE;
         {3'h5, `STEP_ONE}: w = `ROM_CHIP2;
         {3'h6, `STEP_ZERO}: w = `ROM_CHIP3_MORE;
         {3'h6, `STEP_ONE}: w = `ROM_CHIP4;
         {3'h7, `STEP_ZERO}: w = `ROM_CHIP1_MORE;
         {3'h7, `STEP_ONE}: w = `ROM_CHIP2_MORE;
         {3'h7, `STEP_TWO}: w = `ROM_CHIP3_MORE;
         {3'h7, `STEP_THREE}: w = `ROM_CHIP4;
         default: w = `ROM_IDLE;
      endcase
      rom_lookup = filter_seq_pkg::rom_word_type'(w);
   endfunction

   logic [`MODE_W-1:0] mode_q;
   logic mode_bit_high;
   logic mode_bit_mid;
   logic mode_bit_low;
   logic ready_sel;
   logic ready_sel_q;
   logic request_q;
   logic trigger_detected;
   logic slope_rise_q;
   logic slope_select_fall;
   logic rise_hit_q;
   logic fall_hit_q;
   logic trigger_prev_q;
   logic edge_latch_clear_bit;
   logic edge_clear;
   logic [`STEP_W-1:0] step_q;
   filter_seq_pkg::seq_state_type state_q;
   filter_seq_pkg::rom_word_type rom_now;
   filter_seq_pkg::rom_word_type rom_next;
   logic [`STEP_W-1:0] step_next;
   logic [`WORD_W-1:0] bus_word;
   logic push_valid;
   logic push_ready;
   logic request_clear;
   logic [3:0] ovl_raw;
   logic chan_a_ovl;
   logic chan_b_ovl;
   logic ovl_a_q;
   logic ovl_b_q;
   logic signed [2*`WORD_W-1:0] real_full;
   logic signed [2*`WORD_W-1:0] imag_full;

   assign mode_bit_low = mode_q[0];
   assign mode_bit_mid = mode_q[1];
   assign mode_bit_high = mode_q[2];

   two_phase_driver phase_drv (
      .clk(clk),
      .srst(srst),
      .timing_clock_in(timing_clock_in),
      .phase_one_q(phase_one_q),
      .phase_two_q(phase_two_q)
   );

   // Input buffer: sync strobe and quadrature products in the same cycle.
   assign real_full = $signed(sample_data) * $signed(cosine_value);
   assign imag_full = $signed(sample_data) * $signed(sine_value);

   always_ff @(posedge clk) begin
      if (srst) begin
         sync_strobe_q <= 1'b0;
         real_product_q <= `WORD_ZERO;
         imag_product_q <= `WORD_ZERO;
      end else begin
         sync_strobe_q <= sample_valid;
         if (sample_valid) begin
            real_product_q <= real_full[`PROD_HI:`PROD_LO];
            imag_product_q <= imag_full[`PROD_HI:`PROD_LO];
         end
      end
   end

   // Mode latch.
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= 3'h0;
      end else if (mode_write_strobe) begin
         mode_q <= io_bus_in[`MODE_HI_BIT:`MODE_LO_BIT];
      end
   end

   // Slope latch and the two edge detectors.
   assign slope_select_fall = io_bus_in[`SLOPE_FALL_BIT];
   assign edge_latch_clear_bit = io_bus_in[`EDGE_CLEAR_BIT];
   assign edge_clear = slope_write_strobe & edge_latch_clear_bit;
   assign trigger_detected = rise_hit_q | fall_hit_q;

   logic slope_fall_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         slope_rise_q <= 1'b0;
         slope_fall_q <= 1'b0;
      end else if (slope_write_strobe) begin
         slope_rise_q <= io_bus_in[`SLOPE_RISE_BIT];
         slope_fall_q <= slope_select_fall;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         trigger_prev_q <= 1'b0;
         rise_hit_q <= 1'b0;
         fall_hit_q <= 1'b0;
         trigger_out_n_q <= 1'b1;
      end else begin
         trigger_prev_q <= trigger_in;
         // A trigger edge in the clearing cycle still counts.
         if (slope_rise_q && trigger_in && !trigger_prev_q) begin
            rise_hit_q <= 1'b1;
         end else if (edge_clear) begin
            rise_hit_q <= 1'b0;
         end
         if (slope_fall_q && !trigger_in && trigger_prev_q) begin
            fall_hit_q <= 1'b1;
         end else if (edge_clear) begin
            fall_hit_q <= 1'b0;
         end
         trigger_out_n_q <= ~trigger_detected;
      end
   end

   // Request flip-flop, set on a rising edge of the selected ready combination while a trigger edge is detected.
   assign ready_sel = ready_pick({mode_bit_high, mode_bit_mid, mode_bit_low},
      chip_result_ready);
   assign request_clear = request_clear_strobe & final_chip_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         ready_sel_q <= 1'b0;
         request_q <= 1'b0;
         memory_access_request_n <= 1'b1;
      end else begin
         ready_sel_q <= ready_sel;
         // A fresh ready edge beats a clear in the same cycle.
         if (ready_sel && !ready_sel_q && trigger_detected) begin
            request_q <= 1'b1;
            memory_access_request_n <= 1'b0;
         end else if (request_clear) begin
            request_q <= 1'b0;
            memory_access_request_n <= 1'b1;
         end
      end
   end

   // Sequencer: step counter, lookup and chip enables.
   assign rom_now = rom_lookup({mode_q, step_q});
   assign step_next = rom_now.count_on ? step_q + `STEP_ONE : `STEP_ZERO;
   assign rom_next = rom_lookup({mode_q, step_next});

   // The shared bus is modelled as a select of the enabled chip.
   always_comb begin
      bus_word = `WORD_ZERO;
      for (int i = 0; i < `CHIPS; i++) begin
         if (!chip_enable_n_q[i]) begin
            bus_word = bus_word
               | chip_data[i*`WORD_W +: `WORD_W];
         end
      end
   end

   assign push_valid = (state_q == filter_seq_pkg::SEQ_PUSH);

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= filter_seq_pkg::SEQ_IDLE;
         step_q <= `STEP_ZERO;
         chip_enable_n_q <= `ENABLES_OFF;
         final_chip_q <= 1'b0;
      end else begin
         case (state_q)
            filter_seq_pkg::SEQ_IDLE: begin
               step_q <= `STEP_ZERO;
               if (request_q) begin
                  chip_enable_n_q <= rom_now.chip_enable_n;
                  state_q <= filter_seq_pkg::SEQ_PUSH;
               end
            end
            filter_seq_pkg::SEQ_PUSH: begin
               // Step only when the buffer took the word, so a stall
               // holds the current chip on the bus.
               if (push_ready) begin
                  step_q <= step_next;
                  if (rom_now.final_step) begin
                     final_chip_q <= 1'b1;
                     chip_enable_n_q <= `ENABLES_OFF;
                     state_q <= filter_seq_pkg::SEQ_DONE;
                  end else begin
                     chip_enable_n_q <= rom_next.chip_enable_n;
                  end
               end
            end
            filter_seq_pkg::SEQ_DONE: begin
               if (request_clear) begin
                  final_chip_q <= 1'b0;
                  step_q <= `STEP_ZERO;
                  state_q <= filter_seq_pkg::SEQ_IDLE;
               end
            end
            default: begin
               state_q <= filter_seq_pkg::SEQ_IDLE;
               chip_enable_n_q <= `ENABLES_OFF;
            end
         endcase
      end
   end

   two_entry_buffer out_buf (
      .clk(clk),
      .srst(srst),
      .in_valid(push_valid),
      .in_ready_q(push_ready),
      .in_data(bus_word),
      .out_valid_q(data_valid_q),
      .out_ready(data_ready),
      .out_data_q(data_bus_q)
   );

   // Overload decode: imaginary-path chips count only in zoom modes.
   assign ovl_raw = overload_in.overload | overload_in.overflow;
   assign chan_a_ovl = ovl_raw[0] | (ovl_raw[1] & mode_bit_high)
      | overload_in.clip_a;
   assign chan_b_ovl = ovl_raw[2] | (ovl_raw[3] & mode_bit_high)
      | overload_in.clip_b;

   always_ff @(posedge clk) begin
      if (srst) begin
         overload_indicator_q <= 1'b0;
         ovl_a_q <= 1'b0;
         ovl_b_q <= 1'b0;
      end else begin
         overload_indicator_q <= chan_a_ovl | chan_b_ovl;
         // Set wins so an overload during the clear is not lost.
         if (chan_a_ovl) begin
            ovl_a_q <= 1'b1;
         end else if (overload_clear_strobe) begin
            ovl_a_q <= 1'b0;
         end
         if (chan_b_ovl) begin
            ovl_b_q <= 1'b1;
         end else if (overload_clear_strobe) begin
            ovl_b_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         io_bus_bit_fifteen <= 1'b0;
         io_bus_bit_zero <= 1'b0;
         io_bus_read_oe_q <= 1'b0;
      end else begin
         io_bus_read_oe_q <= overload_read_gate;
         io_bus_bit_fifteen <= overload_read_gate & ovl_a_q;
         io_bus_bit_zero <= overload_read_gate & ovl_b_q;
      end
   end

endmodule

/* testbench/host_model.sv */
// Receiver on the data bus that stalls on demand and keeps recent words.
`timescale 1ns/1ps
`include "filter_seq_cfg.svh"
module host_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic stall,
   input wire logic data_valid_q,
   input wire logic [`WORD_W-1:0] data_bus_q,
   output logic data_ready,
   output logic [4*`WORD_W-1:0] words_q,
   output logic [7:0] count_q
);
   logic [2:0] tick_q;
   // A stall accepts one cycle in eight, so both buffer entries fill.
   assign data_ready = !stall || tick_q == 3'h0;
   always_ff @(posedge clk) begin
      if (srst) begin
         tick_q <= 3'h0;
         words_q <= '0;
         count_q <= 8'h0;
      end else begin
         tick_q <= tick_q + 3'h1;
         if (data_valid_q && data_ready) begin
            words_q <= {words_q[3*`WORD_W-1:0], data_bus_q};
            count_q <= count_q + 8'h1;
         end
      end
   end
endmodule

/* testbench/frs_chk.sv */
// Port checker for the filter readout sequencer, with its bind.
`timescale 1ns/1ps
`include "filter_seq_cfg.svh"
module frs_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic phase_one_q,
   input wire logic phase_two_q,
   input wire logic sample_valid,
   input wire logic sync_strobe_q,
   input wire logic [`CHIPS-1:0] chip_result_ready,
   input wire logic [`CHIPS-1:0] chip_enable_n_q,
   input wire logic [`WORD_W-1:0] io_bus_in,
   input wire logic mode_write_strobe,
   input wire logic request_clear_strobe,
   input wire logic memory_access_request_n,
   input wire logic final_chip_q,
   input wire filter_seq_pkg::overload_in_type overload_in,
   input wire logic overload_indicator_q,
   input wire logic overload_read_gate,
   input wire logic io_bus_bit_fifteen,
   input wire logic io_bus_bit_zero,
   input wire logic io_bus_read_oe_q,
   input wire logic trigger_out_n_q
);
   localparam logic [3:0] need_tab [8] = '{4'h2, 4'h1, 4'h4, 4'h5,
      4'h8, 4'h3, 4'hc, 4'hf};
   logic [2:0] mode_q;
   logic [3:0] hit;
   logic ind_a;
   logic ind_b;
   logic sel;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // The mode latch is internal, so the checker keeps its own copy.
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= 3'h0;
      end else if (mode_write_strobe) begin
         mode_q <= io_bus_in[2:0];
      end
   end
   always_comb begin
      hit = overload_in.overload | overload_in.overflow;
      ind_a = hit[0] | (hit[1] & mode_q[2]) | overload_in.clip_a;
      ind_b = hit[2] | (hit[3] & mode_q[2]) | overload_in.clip_b;
      sel = &(chip_result_ready | ~need_tab[mode_q]);
   end
   phase_excl_a: assert property (!(phase_one_q && phase_two_q))
      else $error("clock phases overlap");
   sync_follow_a: assert property (sample_valid |=> sync_strobe_q)
      else $error("sync strobe missing");
   req_raise_a: assert property (!trigger_out_n_q && sel && !$past(sel)
      |=> !memory_access_request_n) else $error("request not raised");
   req_hold_a: assert property (!memory_access_request_n &&
      !(request_clear_strobe && final_chip_q) |=> !memory_access_request_n)
      else $error("request dropped early");
   req_release_a: assert property (request_clear_strobe && final_chip_q
      && !sel |=> memory_access_request_n && !final_chip_q)
      else $error("request not cleared");
   trig_gate_a: assert property (memory_access_request_n ##1
      trigger_out_n_q |-> memory_access_request_n)
      else $error("request without trigger");
   enable_single_a: assert property ($onehot0(~chip_enable_n_q))
      else $error("two chips enabled");
   enable_req_a: assert property (chip_enable_n_q != 4'hf |->
      !memory_access_request_n) else $error("enable without request");
   final_quiet_a: assert property (final_chip_q |->
      chip_enable_n_q == 4'hf && !memory_access_request_n)
      else $error("final flag out of place");
   ovl_now_a: assert property (1'b1 |=>
      overload_indicator_q == $past(ind_a | ind_b))
      else $error("indicator wrong");
   held_read_a: assert property (ind_a && overload_read_gate ##1
      overload_read_gate |=> io_bus_bit_fifteen)
      else $error("held overload lost");
   read_gate_a: assert property (!overload_read_gate |=>
      !io_bus_bit_fifteen && !io_bus_bit_zero && !io_bus_read_oe_q)
      else $error("bus driven without gate");
   cover property (!memory_access_request_n ##1 final_chip_q);
   cover property ($fell(trigger_out_n_q));
   cover property (io_bus_bit_zero);
endmodule
bind filter_readout_sequencer frs_chk chk (.*);

/* testbench/tb_filter_readout_sequencer.sv */
// Self-checking bench for the filter readout sequencer.
`timescale 1ns/1ps
`include "filter_seq_cfg.svh"
module tb_filter_readout_sequencer;
   localparam logic [3:0] need_tab [8] = '{4'h2, 4'h1, 4'h4, 4'h5,
      4'h8, 4'h3, 4'hc, 4'hf};
   logic clk = 1'b0;
   logic srst, phase_one_q, phase_two_q, sample_valid;
   logic timing_clock_in = 1'b0;
   logic sync_strobe_q, mode_write_strobe, request_clear_strobe, stall;
   logic memory_access_request_n, final_chip_q, data_valid_q, data_ready;
   logic overload_indicator_q, overload_clear_strobe, overload_read_gate;
   logic io_bus_bit_fifteen, io_bus_bit_zero, io_bus_read_oe_q;
   logic slope_write_strobe, trigger_in, trigger_out_n_q;
   logic [`WORD_W-1:0] sample_data, cosine_value, sine_value, io_bus_in;
   logic [`WORD_W-1:0] real_product_q, imag_product_q, data_bus_q;
   logic [`CHIPS-1:0] chip_result_ready, chip_enable_n_q;
   logic [`CHIPS*`WORD_W-1:0] chip_data, words_q;
   logic [7:0] count_q;
   logic [7:0] tdiv_q = 8'h0;
   filter_seq_pkg::overload_in_type overload_in;
   int failures = 0;
   int n_tests = 0;
   filter_readout_sequencer dut (.*);
   host_model host (.*);
   assign chip_data = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
   always #10 clk = ~clk;
   always @(posedge clk) begin
      tdiv_q <= tdiv_q + 8'h1;
      timing_clock_in <= tdiv_q[2];
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic fail_wait;
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
   endtask
   task automatic wr(input logic slope, input logic [15:0] v);
      @(posedge clk);
      io_bus_in <= v;
      mode_write_strobe <= !slope;
      slope_write_strobe <= slope;
      @(posedge clk);
      mode_write_strobe <= 1'b0;
      slope_write_strobe <= 1'b0;
   endtask
   task automatic pulse_clear;
      @(posedge clk);
      request_clear_strobe <= 1'b1;
      @(posedge clk);
      request_clear_strobe <= 1'b0;
      @(negedge clk);
   endtask
   // The output moves on the second edge after the input changes.
   task automatic trig(input logic v, input logic exp_n);
      @(posedge clk);
      trigger_in <= v;
      @(posedge clk);
      @(negedge clk);
      check(trigger_out_n_q, 1'b1);
      @(negedge clk);
      check(trigger_out_n_q, exp_n);
   endtask
   task automatic run_mode(input logic [2:0] m);
      logic [63:0] exp, mask;
      logic [7:0] base;
      int n, k;
      exp = '0;
      n = 0;
      for (int i = 0; i < 4; i++) begin
         if (need_tab[m][i]) begin
            exp = {exp[47:0], 16'h1111 * 16'(i + 1)};
            n++;
         end
      end
      mask = (n == 4) ? '1 : (64'h1 << (16 * n)) - 64'h1;
      base = count_q;
      wr(1'b0, {13'h0, m});
      @(posedge clk);
      stall <= m[0];
      chip_result_ready <= need_tab[m];
      @(posedge clk);
      chip_result_ready <= 4'h0;
      @(negedge clk);
      check(memory_access_request_n, 1'b0);
      pulse_clear();
      check(memory_access_request_n, 1'b0);
      for (k = 0; k < 400 && final_chip_q !== 1'b1; k++) @(negedge clk);
      if (k == 400) fail_wait();
      for (k = 0; k < 400 && count_q != base + 8'(n); k++) @(negedge clk);
      if (k == 400) fail_wait();
      check(words_q & mask, exp);
      check(chip_enable_n_q, 4'hf);
      pulse_clear();
      check({memory_access_request_n, final_chip_q}, 2'b10);
      $display("mode %0d test done", m);
   endtask
   // Overload is applied, read through the gate, then cleared as it goes.
   task automatic filter_overload(input logic [9:0] v, input logic [2:0] exp);
      @(posedge clk);
      overload_in <= v;
      overload_read_gate <= 1'b1;
      repeat (3) @(posedge clk);
      overload_in <= '0;
      overload_clear_strobe <= 1'b1;
      @(negedge clk);
      check(overload_indicator_q, exp[2]);
      check({io_bus_bit_fifteen, io_bus_bit_zero}, exp[1:0]);
      @(posedge clk);
      overload_clear_strobe <= 1'b0;
   endtask
   initial begin
      int k;
      srst = 1'b1;
      chip_result_ready = 4'h0;
      overload_in = '0;
      {sample_data, cosine_value, sine_value, io_bus_in} = '0;
      {sample_valid, mode_write_strobe, request_clear_strobe, stall} = '0;
      {overload_clear_strobe, overload_read_gate} = '0;
      {slope_write_strobe, trigger_in} = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      check(chip_enable_n_q, 4'hf);
      check({memory_access_request_n, final_chip_q}, 2'b10);
      for (k = 0; k < 20 && phase_one_q !== 1'b1; k++) @(negedge clk);
      if (k == 20) fail_wait();
      check({phase_one_q, phase_two_q}, 2'b10);
      @(posedge clk);
      sample_data <= 16'h4000;
      cosine_value <= 16'h4000;
      sine_value <= 16'hc000;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(negedge clk);
      check(sync_strobe_q, 1'b1);
      check({real_product_q, imag_product_q}, 32'h2000e000);
      $display("input test done");
      wr(1'b0, 16'h0001);
      @(posedge clk);
      chip_result_ready <= 4'h1;
      @(posedge clk);
      chip_result_ready <= 4'h0;
      @(negedge clk);
      check(memory_access_request_n, 1'b1);
      wr(1'b1, 16'h0002);
      trig(1'b1, 1'b1);
      trig(1'b0, 1'b0);
      wr(1'b1, 16'h0004);
      repeat (2) @(negedge clk);
      check(trigger_out_n_q, 1'b1);
      wr(1'b1, 16'h0001);
      trig(1'b1, 1'b0);
      $display("trigger test done");
      for (int m = 0; m < 8; m++) run_mode(3'(m));
      wr(1'b0, 16'h0000);
      filter_overload(10'h080, 3'b000);
      filter_overload(10'h004, 3'b110);
      filter_overload(10'h001, 3'b101);
      @(negedge clk);
      check(io_bus_read_oe_q, 1'b1);
      wr(1'b0, 16'h0004);
      filter_overload(10'h080, 3'b110);
      filter_overload(10'h200, 3'b101);
      $display("overload test done");
      final_report();
   end
endmodule
